/* File: logic/ssw_defs.svh */
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

// command opcodes
`define SSW_OP_WRITE_ENABLE 8'h06
`define SSW_OP_WRITE_DISABLE 8'h04
`define SSW_OP_STATUS_READ 8'h05
`define SSW_OP_STATUS_WRITE 8'h01
`define SSW_OP_ARRAY_WRITE 8'h02
`define SSW_OP_SECTOR_WRITE 8'h42
`define SSW_OP_SERIAL_WRITE 8'hC2

// status field positions
`define SSW_BIT_PIN_GUARD 7
`define SSW_BIT_GUARD_HI 3
`define SSW_BIT_GUARD_LO 2
`define SSW_BIT_LATCH 1
`define SSW_STATUS_RESET 8'h40
`define SSW_STATUS_FIXED 8'h40

// block guard encodings and bounds
`define SSW_GUARD_NONE 2'h0
`define SSW_GUARD_QUARTER 2'h1
`define SSW_GUARD_HALF 2'h2
`define SSW_GUARD_ALL 2'h3
`define SSW_QUARTER_BASE 21'h180000
`define SSW_HALF_BASE 21'h100000
`define SSW_ARRAY_TOP 21'h1FFFFF

// serial framing
`define SSW_BIT_LAST 3'h7
`define SSW_BIT_FIRST 3'h0

`endif

/* File: logic/ssw_pkg.sv */
package ssw_pkg;

  typedef enum logic [2:0] {
    SSW_PH_OPCODE = 3'b001,
    SSW_PH_PAYLOAD = 3'b010,
    SSW_PH_IGNORE = 3'b100
  } ssw_phase_e;

  typedef logic [20:0] ssw_addr_t;

endpackage : ssw_pkg

/* File: logic/ssw_status_guard.sv */
`timescale 1ns/1ps
`include "ssw_defs.svh"

module ssw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : ssw_sync

module ssw_status_guard (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  input wire logic protect_n_i,
  input wire logic [1:0] nv_guard_i,
  output logic [1:0] nv_guard_o,
  output logic [7:0] status_o,
  input wire logic [20:0] arr_addr_i,
  output logic arr_wr_ok_o
);

  // reset release through two flops
  logic rst_meta_q;
  logic rst_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // ---------------- link side, on the serial clock ----------------
  ssw_pkg::ssw_phase_e phase_q, phase_d;
  logic [2:0] cnt_q, cnt_d;
  logic [6:0] shift_q, shift_d;
  logic started_q, started_d;
  logic [7:0] opcode_q, opcode_d;
  logic [7:0] payload_q, payload_d;
  logic op_done_q, op_done_d;
  logic pay_done_q, pay_done_d;
  logic [7:0] link_stat_meta_q;
  logic [7:0] link_stat_q;
  logic so_q, so_d;
  logic so_oe_q, so_oe_d;
  logic [7:0] status_q, status_d;
  logic [7:0] byte_w;

  always_comb begin
    byte_w = {shift_q, spi_si_i};
    phase_d = phase_q;
    cnt_d = 3'(cnt_q + 3'h1);
    shift_d = byte_w[6:0];
    started_d = 1'b1;
    opcode_d = opcode_q;
    payload_d = payload_q;
    op_done_d = op_done_q;
    pay_done_d = pay_done_q;
    // results of the previous frame are dropped on the next frame's first edge
    if (!started_q) begin
      op_done_d = 1'b0;
      pay_done_d = 1'b0;
    end
    case (phase_q)
      ssw_pkg::SSW_PH_OPCODE: begin
        if (cnt_q == `SSW_BIT_LAST) begin
          opcode_d = byte_w;
          op_done_d = 1'b1;
          if (byte_w == `SSW_OP_STATUS_READ ||
              byte_w == `SSW_OP_STATUS_WRITE) begin
            phase_d = ssw_pkg::SSW_PH_PAYLOAD;
          end else begin
            phase_d = ssw_pkg::SSW_PH_IGNORE;
          end
        end
      end
      ssw_pkg::SSW_PH_PAYLOAD: begin
        if (cnt_q == `SSW_BIT_LAST) begin
          payload_d = byte_w;
          pay_done_d = 1'b1;
          phase_d = ssw_pkg::SSW_PH_IGNORE;
        end
      end
      ssw_pkg::SSW_PH_IGNORE: begin
        // extra bytes are ignored until select rises
        cnt_d = cnt_q;
      end
      default: begin
        phase_d = ssw_pkg::SSW_PH_OPCODE;
        cnt_d = `SSW_BIT_FIRST;
      end
    endcase
  end

  // select high holds the frame state in reset
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      phase_q <= ssw_pkg::SSW_PH_OPCODE;
      cnt_q <= `SSW_BIT_FIRST;
      shift_q <= 7'h00;
      started_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      started_q <= started_d;
    end
  end

  // results must survive the select rise, so only system reset
  always_ff @(posedge spi_sck_i or negedge rst_q) begin
    if (!rst_q) begin
      opcode_q <= 8'h00;
      payload_q <= 8'h00;
      op_done_q <= 1'b0;
      pay_done_q <= 1'b0;
    end else begin
      opcode_q <= opcode_d;
      payload_q <= payload_d;
      op_done_q <= op_done_d;
      pay_done_q <= pay_done_d;
    end
  end

  // status only changes while select is high, so it is settled
  // before the second frame edge and stable through the read
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      link_stat_meta_q <= `SSW_STATUS_RESET;
      link_stat_q <= `SSW_STATUS_RESET;
    end else begin
      link_stat_meta_q <= status_q;
      link_stat_q <= link_stat_meta_q;
    end
  end

  always_comb begin
    so_d = link_stat_q[3'(`SSW_BIT_LAST - cnt_q)];
    so_oe_d = (phase_q == ssw_pkg::SSW_PH_PAYLOAD) &&
              (opcode_q == `SSW_OP_STATUS_READ);
  end

  // output changes on the falling edge for modes 0 and 3
  always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  assign spi_so_o = so_q;
  assign spi_so_oe_o = so_oe_q;

  // ---------------- system side, on clock_i ----------------
  logic cs_sync_w;
  logic wp_sync_w;
  logic [17:0] frame_sync_w;
  logic cs_prev_q;
  logic cs_rise_w;
  logic latch_q, latch_d;
  logic pin_guard_q, pin_guard_d;
  logic [1:0] guard_q, guard_d;
  logic init_q, init_d;
  logic armed_q, armed_d;
  logic arr_ok_q, arr_ok_d;
  logic status_wr_ok_w;
  logic arr_prot_w;
  logic [7:0] f_opcode_w;
  logic [7:0] f_payload_w;
  logic f_op_done_w;
  logic f_pay_done_w;

  ssw_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_q),
    .d_i(spi_cs_n_i),
    .q_o(cs_sync_w)
  );

  ssw_sync #(.W(1), .INIT(1'b1)) u_wp_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_q),
    .d_i(protect_n_i),
    .q_o(wp_sync_w)
  );

  // frame results are frozen once the serial clock stops
  ssw_sync #(.W(18), .INIT(18'h00000)) u_frame_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_q),
    .d_i({op_done_q, pay_done_q, opcode_q, payload_q}),
    .q_o(frame_sync_w)
  );

  assign f_op_done_w = frame_sync_w[17];
  assign f_pay_done_w = frame_sync_w[16];
  assign f_opcode_w = frame_sync_w[15:8];
  assign f_payload_w = frame_sync_w[7:0];
  // flop after the sync only finds the select rise, seen in the cycle the synced select goes high
  assign cs_rise_w = cs_sync_w && !cs_prev_q;
  // pin only counts while the pin guard is set
  assign status_wr_ok_w = latch_q &&
                          !(pin_guard_q && !wp_sync_w);

  always_comb begin
    latch_d = latch_q;
    pin_guard_d = pin_guard_q;
    guard_d = guard_q;
    init_d = 1'b1;
    // an empty select pulse must not replay the last command
    armed_d = armed_q || !f_op_done_w;
    if (!init_q) begin
      guard_d = nv_guard_i;
    end else if (cs_rise_w && f_op_done_w && armed_q) begin
      armed_d = 1'b0;
      case (f_opcode_w)
        `SSW_OP_WRITE_ENABLE: latch_d = 1'b1;
        `SSW_OP_WRITE_DISABLE: latch_d = 1'b0;
        `SSW_OP_STATUS_WRITE: begin
          if (f_pay_done_w) begin
            // refused writes keep the old contents
            if (status_wr_ok_w) begin
              pin_guard_d = f_payload_w[`SSW_BIT_PIN_GUARD];
              guard_d = {f_payload_w[`SSW_BIT_GUARD_HI],
                         f_payload_w[`SSW_BIT_GUARD_LO]};
            end
            latch_d = 1'b0;
          end
        end
        `SSW_OP_ARRAY_WRITE,
        `SSW_OP_SECTOR_WRITE,
        `SSW_OP_SERIAL_WRITE: latch_d = 1'b0;
        default: latch_d = latch_q;
      endcase
    end
  end

  always_comb begin
    status_d = `SSW_STATUS_FIXED;
    status_d[`SSW_BIT_PIN_GUARD] = pin_guard_q;
    status_d[`SSW_BIT_GUARD_HI] = guard_q[1];
    status_d[`SSW_BIT_GUARD_LO] = guard_q[0];
    status_d[`SSW_BIT_LATCH] = latch_q;
  end

  always_comb begin
    case (guard_q)
      `SSW_GUARD_NONE: arr_prot_w = 1'b0;
      `SSW_GUARD_QUARTER: arr_prot_w = (arr_addr_i >= `SSW_QUARTER_BASE) &&
                                       (arr_addr_i <= `SSW_ARRAY_TOP);
      `SSW_GUARD_HALF: arr_prot_w = (arr_addr_i >= `SSW_HALF_BASE) &&
                                    (arr_addr_i <= `SSW_ARRAY_TOP);
      `SSW_GUARD_ALL: arr_prot_w = 1'b1;
      default: arr_prot_w = 1'b1;
    endcase
    // answered every cycle with no busy state; pin not consulted
    arr_ok_d = latch_q && !arr_prot_w;
  end

  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      cs_prev_q <= 1'b1;
      latch_q <= 1'b0;
      pin_guard_q <= 1'b0;
      guard_q <= `SSW_GUARD_NONE;
      init_q <= 1'b0;
      armed_q <= 1'b0;
      arr_ok_q <= 1'b0;
      status_q <= `SSW_STATUS_RESET;
    end else begin
      cs_prev_q <= cs_sync_w;
      latch_q <= latch_d;
      pin_guard_q <= pin_guard_d;
      guard_q <= guard_d;
      init_q <= init_d;
      armed_q <= armed_d;
      arr_ok_q <= arr_ok_d;
      status_q <= status_d;
    end
  end

  assign status_o = status_q;
  assign nv_guard_o = guard_q;
  assign arr_wr_ok_o = arr_ok_q;

endmodule : ssw_status_guard

/* File: verif/ssw_status_guard_props.sv */
`timescale 1ns/1ps
module ssw_status_guard_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  input wire logic spi_so_o,
  input wire logic spi_so_oe_o,
  input wire logic protect_n_i,
  input wire logic [1:0] nv_guard_i,
  input wire logic [1:0] nv_guard_o,
  input wire logic [7:0] status_o,
  input wire logic [20:0] arr_addr_i,
  input wire logic arr_wr_ok_o
);
  logic [3:0] age_q;
  logic [3:0] age_d;
  function automatic logic guarded(logic [1:0] g, logic [20:0] a);
    case (g)
      2'h0: guarded = 1'b0;
      2'h1: guarded = a >= 21'h180000;
      2'h2: guarded = a >= 21'h100000;
      default: guarded = 1'b1;
    endcase
  endfunction : guarded
  // age masks the one-off guard load after reset
  always_comb age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) age_q <= 4'h0;
    else age_q <= age_d;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_fixed_bits: assert property (
    status_o[6:4] == 3'h4 && !status_o[0]) else $error("fixed bits off");
  chk_guard_mirror: assert property (
    status_o[3:2] != nv_guard_o |-> ##[1:3] status_o[3:2] == nv_guard_o)
    else $error("guard store mismatch");
  chk_arr_decode: assert property (
    $stable(status_o) [*3] |-> arr_wr_ok_o ==
      (status_o[1] && !guarded(status_o[3:2], $past(arr_addr_i))))
    else $error("array permit wrong");
  chk_latch_arr: assert property (
    !status_o[1] [*3] |-> !arr_wr_ok_o) else $error("write without latch");
  chk_frame_end: assert property (
    $changed(status_o) |-> $past(spi_cs_n_i, 3))
    else $error("status moved mid frame");
  chk_so_idle: assert property (
    spi_cs_n_i |-> !spi_so_oe_o) else $error("so driven while idle");
  chk_guard_latch: assert property (
    age_q == 4'hF && $changed({status_o[7], status_o[3:2]})
      |-> $past(status_o[1]) || $past(status_o[1], 2))
    else $error("guard changed without latch");
  chk_so_first: assert property (
    $rose(spi_so_oe_o) |-> spi_so_o == status_o[7])
    else $error("first status bit wrong");
  cover property ($rose(status_o[1]));
  cover property (status_o[3:2] == 2'h3 && status_o[1]);
  cover property ($rose(spi_so_oe_o));
endmodule : ssw_status_guard_chk

bind ssw_status_guard ssw_status_guard_chk i_chk (.clock_i, .rst_n_i,
  .spi_sck_i, .spi_cs_n_i, .spi_si_i, .spi_so_o, .spi_so_oe_o, .protect_n_i,
  .nv_guard_i, .nv_guard_o, .status_o, .arr_addr_i, .arr_wr_ok_o);

/* File: verif/ssw_master.sv */
`timescale 1ns/1ps
module ssw_master (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic flip = 1'b0;
  logic so_w;
  // released line toggles so a stale bit never reads as good
  assign so_w = so_oe_i ? so_i : flip;
  always @(posedge sck_o) flip <= ~flip;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // mode 0, msb first; sck stands still between frames
  task automatic xfer(input logic [31:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    #13 cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      si_o = tx[31-i];
      #80 sck_o = 1'b1;
      if (i >= 8) rx = {rx[6:0], so_w};
      #80 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o;
    #400;
  endtask : xfer
endmodule : ssw_master

/* File: verif/ssw_status_guard_test.sv */
`timescale 1ns/1ps
module ssw_status_guard_test;
  logic clock_i, rst_n_i, protect_n_i, sck, cs_n, si, so, so_oe, ok;
  logic [1:0] nv_i, nvo;
  logic [7:0] st, rx, d;
  logic [20:0] addr;
  logic [31:0] r;
  logic [31:0] seed = 32'hA0E3A259;
  int fails = 0, n_checks = 0, m_lat = 0, m_pg = 0, m_g;
  ssw_status_guard i_ssw_status_guard (.clock_i, .rst_n_i, .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .protect_n_i, .nv_guard_i(nv_i), .nv_guard_o(nvo), .status_o(st),
    .arr_addr_i(addr), .arr_wr_ok_o(ok));
  ssw_master i_ssw_master (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .so_i(so), .so_oe_i(so_oe));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] mst();
    return {m_pg[0], 3'h4, m_g[1:0], m_lat[0], 1'b0};
  endfunction : mst
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic cmd(logic [7:0] op, logic [7:0] dat, int nb);
    i_ssw_master.xfer({op, dat, 16'h0000}, nb, rx);
    if (op == 8'h06) m_lat = 1;
    if (op == 8'h04 || op == 8'h02) m_lat = 0;
    if (op == 8'h01) begin
      if (m_lat != 0 && !(m_pg != 0 && !protect_n_i)) begin
        m_pg = dat[7];
        m_g = dat[3:2];
      end
      m_lat = 0;
    end
    repeat (10) @(posedge clock_i);
    #1;
    if (op == 8'h05) check("status read", rx, mst());
    check("status", st, mst());
    check("guard store", {6'h00, nvo}, {6'h00, m_g[1:0]});
  endtask : cmd
  task automatic arrs();
    logic [20:0] tbl[6] = '{21'h000000, 21'h0FFFFF, 21'h100000,
      21'h17FFFF, 21'h180000, 21'h1FFFFF};
    logic e;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      @(posedge clock_i);
      addr <= (i < 6) ? tbl[i] : r[20:0];
      protect_n_i <= r[25];
      @(posedge clock_i);
      #1;
      e = m_lat != 0 && !(m_g == 3 || (m_g == 1 && addr >= 21'h180000)
        || (m_g == 2 && addr >= 21'h100000));
      check("arr ok", {7'h00, ok}, {7'h00, e});
    end
  endtask : arrs
  initial begin
    rst_n_i = 1'b0;
    protect_n_i = 1'b1;
    addr = 21'h000000;
    r = xs();
    nv_i = r[1:0];
    m_g = r[1:0];
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    cmd(8'h05, 8'h00, 16);
    cmd(8'h01, 8'h8C, 16);
    cmd(8'h06, 8'h00, 8);
    cmd(8'h04, 8'h00, 8);
    cmd(8'h06, 8'h00, 8);
    cmd(8'h01, 8'h80, 16);
    @(posedge clock_i) protect_n_i <= 1'b0;
    cmd(8'h06, 8'h00, 8);
    cmd(8'h01, 8'h0C, 16);
    @(posedge clock_i) protect_n_i <= 1'b1;
    cmd(8'h06, 8'h00, 8);
    cmd(8'h01, 8'h7F, 16);
    @(posedge clock_i) protect_n_i <= 1'b0;
    cmd(8'h06, 8'h00, 8);
    cmd(8'h01, 8'h00, 16);
    $display("test directed done");
    for (int k = 0; k < 8; k++) begin
      r = xs();
      d = r[7:0];
      if (k < 4) d = {1'b0, d[6:4], k[1:0], d[1:0]};
      @(posedge clock_i) protect_n_i <= (k < 4) | r[9];
      cmd(8'h06, 8'h00, 8);
      cmd(8'h01, d, 16);
      cmd(8'h05, 8'h00, 16);
      cmd(8'h06, 8'h00, 8);
      arrs();
      cmd(8'h02, r[15:8], 32);
      arrs();
      $display("test %0d done", k);
    end
    cmd(8'h06, 8'h00, 8);
    @(posedge clock_i) rst_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    m_lat = 0;
    m_pg = 0;
    m_g = nv_i;
    repeat (8) @(posedge clock_i);
    #1;
    check("reset status", st, mst());
    check("reset guard", {6'h00, nvo}, {6'h00, nv_i});
    arrs();
    $display("test reset done");
    wrap_up();
  end
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule : ssw_status_guard_test
